// >>> wdpm_pkg.sv
/*
  Shared constants for the watchdog and power mode controller:
  register indices, field positions, reset values, divider sizes and
  state types. Assumes nothing of its surroundings.
*/
package wdpm_pkg;
  // Register indices; the byte address is four times the index
  localparam logic [7:0] IDX_PRESCALE = 8'h09;
  localparam logic [7:0] IDX_PWRCTL = 8'h26;
  localparam logic [11:0] ADDR_PRESCALE = {2'h0, IDX_PRESCALE, 2'h0};
  localparam logic [11:0] ADDR_PWRCTL = {2'h0, IDX_PWRCTL, 2'h0};
  localparam logic [7:0] PRESCALE_RST = 8'h07;
  localparam logic [7:0] PWRCTL_RST = 8'h00;
  localparam logic [7:0] PWRCTL_WMASK = 8'hE0;
  localparam int unsigned RATIO_MSB = 2;
  localparam int unsigned FREQ_UP_BIT = 5;
  localparam int unsigned OSC_OFF_BIT = 6;
  localparam int unsigned FAST_CLK_BIT = 7;
  localparam int unsigned DIV_STAGES = 9;
  localparam int unsigned PRE_STAGES = 7;
  localparam logic [1:0] INSTR_DIV_LAST = 2'h3;
  localparam int unsigned START_DELAY_CYC = 1024;
  localparam logic [1:0] SRC_RC = 2'h0;
  localparam logic [1:0] SRC_XTAL = 2'h1;
  localparam logic [1:0] SRC_INSTR = 2'h2;
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_GREEN = 2'h1;
  localparam logic [1:0] MODE_SLEEP = 2'h2;
  localparam logic [1:0] MODE_IDLE = 2'h3;
  typedef enum logic [1:0] {WDPM_RUN, WDPM_SLEEP, WDPM_IDLE, WDPM_WAKE} wdpm_state_t;
endpackage

// >>> wdpm_top.sv
/*
  Watchdog timer with prescaler, plus operation mode and clock control,
  reached over APB. Assumes straps are static, CPU event inputs are
  one-cycle pulses on pclk, and oscillator/system clocks arrive as pins.
*/
// Added by the designer: register access over APB.
`timescale 1ns/10ps
module wdpm_top
  import wdpm_pkg::*;
#(
  parameter int unsigned START_DELAY = START_DELAY_CYC
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic dog_en_opt,
  input wire logic [1:0] dog_src_opt,
  input wire logic dual_clear_opt,
  input wire logic dog_rc_osc,
  input wire logic xtal_clk_pin,
  input wire logic sys_clk_pin,
  input wire logic ext_clear_pin_n,
  input wire logic halt_exec,
  input wire logic dog_clear_single,
  input wire logic dog_clear_first,
  input wire logic dog_clear_second,
  input wire logic wake_irq,
  input wire logic wake_porta,
  output logic rc_osc_en,
  output logic xtal_osc_en,
  output logic freq_up_on,
  output logic fast_clock_sel,
  output logic [1:0] op_mode,
  output logic start_delay_timer,
  output logic expiry_flag,
  output logic halt_flag,
  output logic chip_reset_req,
  output logic warm_reset_req
);
  localparam int unsigned CW = DIV_STAGES + PRE_STAGES;
  localparam int unsigned DW = $clog2(START_DELAY + 1);
  localparam logic [DW-1:0] DLY_LAST = DW'(START_DELAY - 1);

  // Pin synchronisers: stage 0 feeds stage 1 only, stage 2 is for edges
  logic [2:0] rc_s, xt_s, sc_s;
  logic [1:0] rs_s, en_s, dual_s;
  logic [1:0] src0_s, src1_s;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rc_s <= 3'h0;
      xt_s <= 3'h0;
      sc_s <= 3'h0;
      rs_s <= 2'h3;
      en_s <= 2'h0;
      dual_s <= 2'h0;
      src0_s <= 2'h0;
      src1_s <= 2'h0;
    end
    else
    begin
      rc_s <= {rc_s[1:0], dog_rc_osc};
      xt_s <= {xt_s[1:0], xtal_clk_pin};
      sc_s <= {sc_s[1:0], sys_clk_pin};
      rs_s <= {rs_s[0], ext_clear_pin_n};
      en_s <= {en_s[0], dog_en_opt};
      dual_s <= {dual_s[0], dual_clear_opt};
      src0_s <= {src0_s[0], dog_src_opt[0]};
      src1_s <= {src1_s[0], dog_src_opt[1]};
    end
  end

  logic dog_en, dual, ext_low;
  logic [1:0] src;
  logic rc_edge, xt_edge, sc_edge;
  assign dog_en = en_s[1];
  assign dual = dual_s[1];
  assign src = {src1_s[1], src0_s[1]};
  assign ext_low = ~rs_s[1];
  assign rc_edge = rc_s[1] & ~rc_s[2];
  assign xt_edge = xt_s[1] & ~xt_s[2];
  assign sc_edge = sc_s[1] & ~sc_s[2];

  // Time-out once bits 0 .. 8+n are all ones at a tick
  function automatic logic dog_hit(input logic [CW-1:0] c, input logic [2:0] n);
    logic [CW-1:0] m;
    m = {CW{1'b1}} >> (3'h7 - n);
    return (c & m) == m;
  endfunction

  wdpm_state_t state, next_state;
  logic [7:0] prescale, next_prescale;
  logic [7:0] pwrctl, next_pwrctl;
  logic [31:0] next_prdata;
  logic [CW-1:0] cnt, next_cnt;
  logic [1:0] idiv, next_idiv;
  logic first_seen, next_first_seen;
  logic second_seen, next_second_seen;
  logic [DW-1:0] dly, next_dly;
  logic next_expiry, next_halt_flag, next_chip_rst, next_warm_rst;
  logic halted, tick, dog_clr, dog_to, halt_take, wake, hit_sel, wr_en;

  assign halted = (state == WDPM_SLEEP) || (state == WDPM_IDLE);
  assign halt_take = halt_exec && (state == WDPM_RUN);
  assign wr_en = psel && penable && pwrite;
  assign hit_sel = (paddr == ADDR_PRESCALE) || (paddr == ADDR_PWRCTL);

  // Watchdog clock source and its gating by mode
  always_comb
  begin
    next_idiv = idiv;
    if (sc_edge)
      next_idiv = idiv + 2'h1;
    case (src)
      SRC_RC: tick = rc_edge;
      SRC_XTAL: tick = xt_edge && (state != WDPM_IDLE);
      SRC_INSTR: tick = sc_edge && (idiv == INSTR_DIV_LAST) && !halted;
      default: tick = 1'b0;
    endcase
  end

  // Clear requests; dual option needs both halves
  always_comb
  begin
    next_first_seen = first_seen;
    next_second_seen = second_seen;
    dog_clr = 1'b0;
    if (dog_en)
    begin
      if (!dual && dog_clear_single)
        dog_clr = 1'b1;
      if (dual)
      begin
        next_first_seen = first_seen | dog_clear_first;
        next_second_seen = second_seen | dog_clear_second;
        if (next_first_seen && next_second_seen)
        begin
          dog_clr = 1'b1;
          next_first_seen = 1'b0;
          next_second_seen = 1'b0;
        end
      end
    end
    if (ext_low || halt_take)
    begin
      next_first_seen = 1'b0;
      next_second_seen = 1'b0;
    end
  end

  // Divider chain and prescaler as one counter
  always_comb
  begin
    dog_to = dog_en && tick && dog_hit(cnt, prescale[RATIO_MSB:0]);
    next_cnt = cnt;
    if (!dog_en)
      next_cnt = '0;
    else if (ext_low || dog_clr || halt_take || dog_to)
      next_cnt = '0;
    else if (tick)
      next_cnt = cnt + 1'b1;
  end

  // Registers over APB; chip reset restores reset values
  always_comb
  begin
    next_prescale = prescale;
    next_pwrctl = pwrctl;
    next_prdata = prdata;
    if (ext_low || (dog_to && !halted))
    begin
      next_prescale = PRESCALE_RST;
      next_pwrctl = PWRCTL_RST;
    end
    // Wake-up keeps the registers but drops the fast clock, so Green follows
    else if (wake)
      next_pwrctl[FAST_CLK_BIT] = 1'b0;
    else if (wr_en && paddr == ADDR_PRESCALE)
      next_prescale = pwdata[7:0];
    else if (wr_en && paddr == ADDR_PWRCTL)
      next_pwrctl = pwdata[7:0] & PWRCTL_WMASK;
    if (psel && !penable)
    begin
      case (paddr)
        ADDR_PRESCALE: next_prdata = {24'h0, prescale};
        ADDR_PWRCTL: next_prdata = {24'h0, pwrctl};
        default: next_prdata = 32'h0;
      endcase
    end
  end

  // Mode machine; wake holds the start-up delay
  always_comb
  begin
    next_state = state;
    next_dly = dly;
    wake = 1'b0;
    case (state)
      WDPM_RUN:
      begin
        if (ext_low || (dog_to))
        begin
          next_state = WDPM_WAKE;
          next_dly = '0;
        end
        else if (halt_take)
          next_state = pwrctl[OSC_OFF_BIT] ? WDPM_IDLE : WDPM_SLEEP;
      end
      WDPM_SLEEP, WDPM_IDLE:
      begin
        if (ext_low || dog_to || wake_irq || wake_porta)
        begin
          wake = 1'b1;
          next_state = WDPM_WAKE;
          next_dly = '0;
        end
      end
      WDPM_WAKE:
      begin
        if (ext_low)
          next_dly = '0;
        else if (sc_edge)
        begin
          if (dly == DLY_LAST)
          begin
            next_state = WDPM_RUN;
            next_dly = '0;
          end
          else
            next_dly = dly + 1'b1;
        end
      end
      default: next_state = WDPM_RUN;
    endcase
  end

  // Status flags; a hardware set wins over a clear in the same cycle
  always_comb
  begin
    next_expiry = expiry_flag;
    next_halt_flag = halt_flag;
    if (dog_en && dog_clr)
    begin
      next_expiry = 1'b0;
      next_halt_flag = 1'b0;
    end
    if (halt_take)
    begin
      next_expiry = 1'b0;
      next_halt_flag = 1'b1;
    end
    if (dog_to)
      next_expiry = 1'b1;
    next_chip_rst = dog_to && !halted;
    next_warm_rst = dog_to && halted;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= WDPM_RUN;
      prescale <= PRESCALE_RST;
      pwrctl <= PWRCTL_RST;
      prdata <= 32'h0;
      cnt <= '0;
      idiv <= 2'h0;
      first_seen <= 1'b0;
      second_seen <= 1'b0;
      dly <= '0;
      expiry_flag <= 1'b0;
      halt_flag <= 1'b0;
      chip_reset_req <= 1'b0;
      warm_reset_req <= 1'b0;
    end
    else
    begin
      state <= next_state;
      prescale <= next_prescale;
      pwrctl <= next_pwrctl;
      prdata <= next_prdata;
      cnt <= next_cnt;
      idiv <= next_idiv;
      first_seen <= next_first_seen;
      second_seen <= next_second_seen;
      dly <= next_dly;
      expiry_flag <= next_expiry;
      halt_flag <= next_halt_flag;
      chip_reset_req <= next_chip_rst;
      warm_reset_req <= next_warm_rst;
    end
  end

  // Zero-wait slave: the access phase always completes
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit_sel;

  assign rc_osc_en = dog_en && (src == SRC_RC);
  assign xtal_osc_en = (state != WDPM_IDLE);
  assign freq_up_on = pwrctl[FREQ_UP_BIT];
  assign fast_clock_sel = pwrctl[FAST_CLK_BIT] && (state == WDPM_RUN);
  assign start_delay_timer = (state == WDPM_WAKE);
  always_comb
  begin
    case (state)
      WDPM_SLEEP: op_mode = MODE_SLEEP;
      WDPM_IDLE: op_mode = MODE_IDLE;
      WDPM_RUN: op_mode = pwrctl[FAST_CLK_BIT] ? MODE_NORMAL : MODE_GREEN;
      default: op_mode = MODE_GREEN;
    endcase
  end

  rc_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state == WDPM_IDLE && dog_en && src == SRC_RC && tick && !ext_low && !dog_clr && !dog_to)
      |-> rc_osc_en ##1 (cnt == $past(cnt) + 1'b1))
    else $error("RC watchdog stalled in Idle");
  quiet_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    !dog_en |=> !chip_reset_req && !warm_reset_req)
    else $error("Reset request from disabled watchdog");
  halt_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    (halt_take && !dog_to) |=> halt_flag && !expiry_flag)
    else $error("Halt flags wrong");
  chip_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
    (dog_to && state == WDPM_RUN) |=> chip_reset_req && expiry_flag && !warm_reset_req)
    else $error("Missing chip reset on time-out");
  warm_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
    (dog_to && halted) |=> warm_reset_req ##1 !warm_reset_req)
    else $error("Warm reset not a single pulse");
  idle_freeze_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state == WDPM_IDLE && src == SRC_XTAL && !ext_low) |=> $stable(cnt))
    else $error("Crystal watchdog counted in Idle");
  wake_delay_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state == WDPM_WAKE && next_state == WDPM_RUN) |-> dly == DLY_LAST && sc_edge)
    else $error("Start-up delay cut short");
  green_forced_a: assert property (@(posedge pclk) disable iff (!presetn)
    chip_reset_req |-> !fast_clock_sel ##1 !fast_clock_sel)
    else $error("Fast clock after reset");
  low_bits_a: assert property (@(posedge pclk) disable iff (!presetn)
    (pwrctl & ~PWRCTL_WMASK) == 8'h00)
    else $error("Power control low bits not zero");
endmodule

// >>> wdpm_top_bench.sv
/*
  Self-checking bench for the watchdog and power mode controller.
  Assumes straps change only between scenarios, the RC, crystal and system
  clock pins are slow square waves made here from pclk, and START_DELAY is 8.
*/
`timescale 1ns/10ps
module wdpm_top_bench;
  import wdpm_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd_val;
  logic pready, pslverr, rd_err;
  logic dog_en_opt = 1, dual_clear_opt = 0, xtal_clk_pin = 0, dog_clear_second = 0;
  logic [1:0] dog_src_opt = SRC_RC, div = 0, op_mode;
  logic dog_rc_osc = 0, sys_clk_pin = 0, ext_clear_pin_n = 1, halt_exec = 0;
  logic dog_clear_single = 0, dog_clear_first = 0, wake_irq = 0, wake_porta = 0;
  logic rc_osc_en, xtal_osc_en, freq_up_on, fast_clock_sel, start_delay_timer;
  logic expiry_flag, halt_flag, chip_reset_req, warm_reset_req;
  int n_mismatch = 0, checks_done = 0, n_chip = 0, n_warm = 0, n, k0, w0;

  wdpm_top #(.START_DELAY(8)) u_wdpm_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .dog_en_opt(dog_en_opt), .dog_src_opt(dog_src_opt),
    .dual_clear_opt(dual_clear_opt), .dog_rc_osc(dog_rc_osc), .xtal_clk_pin(xtal_clk_pin),
    .sys_clk_pin(sys_clk_pin), .ext_clear_pin_n(ext_clear_pin_n), .halt_exec(halt_exec),
    .dog_clear_single(dog_clear_single), .dog_clear_first(dog_clear_first),
    .dog_clear_second(dog_clear_second), .wake_irq(wake_irq), .wake_porta(wake_porta),
    .rc_osc_en(rc_osc_en), .xtal_osc_en(xtal_osc_en), .freq_up_on(freq_up_on),
    .fast_clock_sel(fast_clock_sel), .op_mode(op_mode), .start_delay_timer(start_delay_timer),
    .expiry_flag(expiry_flag), .halt_flag(halt_flag), .chip_reset_req(chip_reset_req),
    .warm_reset_req(warm_reset_req));

  always #5 pclk = ~pclk;

  // All slow clocks run free: a tick every 4 pclk keeps each level 2 pclk long
  always @(posedge pclk)
  begin
    div <= div + 2'h1;
    dog_rc_osc <= div[1];
    sys_clk_pin <= div[1];
    xtal_clk_pin <= div[1];
    if (chip_reset_req === 1'b1)
      n_chip <= n_chip + 1;
    if (warm_reset_req === 1'b1)
      n_warm <= n_warm + 1;
  end

  task automatic conclude();
    if (n_mismatch == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    if (i == 20)
    begin
      n_mismatch++;
      conclude();
    end
    rd_val = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd_val, exp);
  endtask

  task automatic pulse(input int k);
    @(posedge pclk);
    case (k)
      0: halt_exec <= 1'b1;
      1: dog_clear_single <= 1'b1;
      2: dog_clear_first <= 1'b1;
      3: wake_irq <= 1'b1;
      4: wake_porta <= 1'b1;
      default: dog_clear_second <= 1'b1;
    endcase
    @(posedge pclk);
    {halt_exec, dog_clear_single, dog_clear_first, wake_irq, wake_porta} <= 5'h00;
    dog_clear_second <= 1'b0;
    #1;
  endtask

  function automatic logic sig(input int k);
    case (k)
      0: return chip_reset_req;
      1: return warm_reset_req;
      default: return start_delay_timer === 1'b0;
    endcase
  endfunction

  // Bounded wait; running out of cycles ends the run as a failure
  task automatic wait_hi(input int k, input int lim);
    for (n = 0; n < lim; n++)
    begin
      @(posedge pclk);
      #1;
      if (sig(k) === 1'b1)
        break;
    end
    if (n == lim)
    begin
      n_mismatch++;
      conclude();
    end
  endtask

  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    #1;
    chk(op_mode, MODE_GREEN);
    chk({rc_osc_en, xtal_osc_en, halt_flag, expiry_flag}, 4'hC);
    rd(ADDR_PRESCALE, PRESCALE_RST);
    rd(ADDR_PWRCTL, PWRCTL_RST);
    apb(1'b1, ADDR_PRESCALE, 32'hFA);
    rd(ADDR_PRESCALE, 32'hFA);
    apb(1'b1, ADDR_PWRCTL, 32'h20);
    apb(1'b1, ADDR_PWRCTL, 32'hFF);
    rd(ADDR_PWRCTL, 32'hE0);
    chk({op_mode, fast_clock_sel, freq_up_on}, {MODE_NORMAL, 2'h3});
    apb(1'b1, ADDR_PWRCTL, 32'h20);
    chk({op_mode, fast_clock_sel, freq_up_on}, {MODE_GREEN, 2'h1});
    apb(1'b0, 12'h000, 32'h0);
    chk({rd_err, rd_val}, {1'b1, 32'h0});
    for (int p = 0; p < 2; p++)
    begin
      apb(1'b1, ADDR_PRESCALE, p);
      pulse(1);
      wait_hi(0, (2048 << p) + 16);
      chk(n >= (2048 << p) - 8, 1);
      chk(expiry_flag, 1'b1);
      @(posedge pclk);
      #1;
      chk(chip_reset_req, 1'b0);
      wait_hi(2, 80);
      rd(ADDR_PRESCALE, PRESCALE_RST);
    end
    // Regular clears well inside the period must hold the reset off
    apb(1'b1, ADDR_PRESCALE, 32'h00);
    k0 = n_chip;
    for (int i = 0; i < 3; i++)
    begin
      repeat (1600) @(posedge pclk);
      pulse(1);
    end
    chk(n_chip, k0);
    repeat (1000) @(posedge pclk);
    pulse(2);
    wait_hi(0, 1200);
    wait_hi(2, 80);
    apb(1'b1, ADDR_PWRCTL, 32'h40);
    pulse(0);
    chk({op_mode, halt_flag, expiry_flag, xtal_osc_en}, {MODE_IDLE, 3'h4});
    repeat (8) @(posedge pclk);
    pulse(3);
    chk(start_delay_timer, 1'b1);
    repeat (20) @(posedge pclk);
    #1;
    chk(start_delay_timer, 1'b1);
    wait_hi(2, 60);
    chk(op_mode, MODE_GREEN);
    apb(1'b1, ADDR_PRESCALE, 32'h00);
    apb(1'b1, ADDR_PWRCTL, 32'h00);
    k0 = n_chip;
    pulse(0);
    chk({op_mode, xtal_osc_en}, {MODE_SLEEP, 1'b1});
    wait_hi(1, 2200);
    chk(n >= 2040, 1);
    chk(n_chip, k0);
    rd(ADDR_PRESCALE, 32'h0);
    wait_hi(2, 80);
    chk(op_mode, MODE_GREEN);
    pulse(0);
    pulse(4);
    wait_hi(2, 80);
    chk(op_mode, MODE_GREEN);
    apb(1'b1, ADDR_PRESCALE, 32'h33);
    @(posedge pclk);
    ext_clear_pin_n <= 1'b0;
    repeat (4) @(posedge pclk);
    ext_clear_pin_n <= 1'b1;
    repeat (3) @(posedge pclk);
    rd(ADDR_PRESCALE, PRESCALE_RST);
    wait_hi(2, 80);
    chk(op_mode, MODE_GREEN);
    // Crystal source: frozen in Idle, still counting in Sleep
    apb(1'b1, ADDR_PRESCALE, 32'h00);
    @(posedge pclk);
    dog_src_opt <= SRC_XTAL;
    apb(1'b1, ADDR_PWRCTL, 32'h40);
    pulse(0);
    w0 = n_warm;
    repeat (2200) @(posedge pclk);
    chk(n_warm, w0);
    pulse(3);
    wait_hi(2, 80);
    apb(1'b1, ADDR_PWRCTL, 32'h00);
    pulse(0);
    wait_hi(1, 2200);
    wait_hi(2, 80);
    // Instruction clock: one tick per four system clock edges, frozen in Sleep
    @(posedge pclk);
    dog_src_opt <= SRC_INSTR;
    pulse(1);
    chk(rc_osc_en, 1'b0);
    wait_hi(0, 8400);
    chk(n >= 8150, 1);
    wait_hi(2, 80);
    apb(1'b1, ADDR_PRESCALE, 32'h00);
    pulse(0);
    w0 = n_warm;
    repeat (8400) @(posedge pclk);
    chk(n_warm, w0);
    pulse(4);
    wait_hi(2, 80);
    // Disabled watchdog: oscillator off and no time-out
    @(posedge pclk);
    dog_en_opt <= 1'b0;
    dog_src_opt <= SRC_RC;
    k0 = n_chip;
    repeat (2200) @(posedge pclk);
    #1;
    chk({rc_osc_en, n_chip == k0}, 2'h1);
    // Dual clear: both halves hold the time-out off, one half does not
    @(posedge pclk);
    dog_en_opt <= 1'b1;
    dual_clear_opt <= 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      repeat (1500) @(posedge pclk);
      pulse(2);
      pulse(5);
    end
    chk(n_chip, k0);
    repeat (1000) @(posedge pclk);
    pulse(1);
    pulse(2);
    wait_hi(0, 1200);
    wait_hi(2, 80);
    conclude();
  end

  initial
  begin
    repeat (80000) @(posedge pclk);
    n_mismatch++;
    conclude();
  end
endmodule
